// ### logic/hdlc_timeslot_attach.sv
// attaches three link controllers to E1 timeslots, controller zero alternatively to the spare frame bits
//
// Operation
// - controller zero enable bit 7 connects/disconnects it
// - path bit 6: 0 spare bits, 1 payload
// - 5-bit channel index picks timeslot 0..31
// - transmit: controller bits replace serial input
// - receive: tap line data before elastic buffer
// - controller one enable bit 7 connects it
// - controller two enable bit 7 connects it
`timescale 1ns/1ps
module hdlc_timeslot_attach (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [tsa_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [tsa_pkg::DATA_W-1:0] PWDATA_I,
  output logic [tsa_pkg::DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic BIT_STROBE_I,
  input wire logic FRAME_START_I,
  input wire logic ALIGN_FRAME_I,
  input wire logic SER_TX_DATA_I,
  input wire logic LINE_RX_DATA_I,
  input wire logic [tsa_pkg::NUM_CTRL-1:0] CTRL_TX_DATA_I,
  output logic TX_DATA_O,
  output logic [tsa_pkg::NUM_CTRL-1:0] CTRL_TX_TAKEN_O,
  output logic [tsa_pkg::NUM_CTRL-1:0] CTRL_RX_DATA_O,
  output logic [tsa_pkg::NUM_CTRL-1:0] CTRL_RX_VALID_O
);
  typedef struct packed {
    logic [tsa_pkg::NUM_CTRL-1:0][tsa_pkg::SEL_W-1:0] sel;
    logic [tsa_pkg::FRAME_POS_W-1:0] next_pos;
    logic tx_data;
    logic [tsa_pkg::NUM_CTRL-1:0] tx_taken;
    logic [tsa_pkg::NUM_CTRL-1:0] rx_data;
    logic [tsa_pkg::NUM_CTRL-1:0] rx_valid;
    logic [tsa_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s st;
  state_s next_st;
  logic [tsa_pkg::FRAME_POS_W-1:0] frame_pos;
  logic [tsa_pkg::NUM_CTRL-1:0] active;

  // the bit being presented now; a frame start forces position zero
  assign frame_pos = FRAME_START_I ? '0 : st.next_pos;

  for (genvar g = 0; g < tsa_pkg::NUM_CTRL; g++) begin : g_ctrl
    slot_if port_if ();
    assign port_if.enable = st.sel[g][tsa_pkg::EN_BIT];
    assign port_if.payload_sel = st.sel[g][tsa_pkg::SPARE_SEL_BIT];
    assign port_if.channel_index = st.sel[g][tsa_pkg::CHAN_LSB +: tsa_pkg::CHAN_W];
    assign port_if.frame_pos = frame_pos;
    assign port_if.align_frame = ALIGN_FRAME_I;
    assign active[g] = port_if.active;
    slot_matcher #(
      .ALLOW_SPARE(g == 0),
      .ALLOW_SLOT_ZERO(g == 0)
    ) u_match (
      .port_if(port_if)
    );
  end

  function automatic logic [tsa_pkg::SEL_W-1:0] reg_mask(input int idx);
    reg_mask = (idx == 0) ? tsa_pkg::MASK_CTRL0 : tsa_pkg::MASK_CTRL12;
  endfunction : reg_mask

  always_comb begin
    logic setup;
    logic access;
    logic hit;
    logic [1:0] idx;
    logic [tsa_pkg::SEL_W-1:0] rd_byte;
    logic tx_bit;
    logic [tsa_pkg::NUM_CTRL-1:0] winner;
    setup = 1'b0;
    access = 1'b0;
    hit = 1'b0;
    idx = 2'h0;
    rd_byte = '0;
    tx_bit = SER_TX_DATA_I;
    winner = '0;
    next_st = st;

    // register decode
    case (PADDR_I)
      tsa_pkg::ADDR_CTRL0: begin
        hit = 1'b1;
        idx = 2'h0;
      end
      tsa_pkg::ADDR_CTRL1: begin
        hit = 1'b1;
        idx = 2'h1;
      end
      tsa_pkg::ADDR_CTRL2: begin
        hit = 1'b1;
        idx = 2'h2;
      end
      default: begin
        hit = 1'b0;
        idx = 2'h0;
      end
    endcase
    if (hit) begin
      rd_byte = st.sel[idx];
    end

    // answer is prepared in the setup cycle so the access phase needs no wait
    setup = PSEL_I && !PENABLE_I;
    access = PSEL_I && PENABLE_I && st.pready;
    next_st.pready = setup;
    if (setup) begin
      next_st.pslverr = !hit;
      next_st.prdata = (hit && !PWRITE_I) ? {{(tsa_pkg::DATA_W-tsa_pkg::SEL_W){1'b0}}, rd_byte}
                                          : '0;
    end else if (!PSEL_I) begin
      next_st.pslverr = 1'b0;
      next_st.prdata = '0;
    end
    // unused bits are not stored and read back as zero
    if (access && PWRITE_I && hit) begin
      next_st.sel[idx] = PWDATA_I[tsa_pkg::SEL_W-1:0] & reg_mask(int'(idx));
    end

    // datapath: one bit per strobe, outputs registered one cycle later
    next_st.tx_taken = '0;
    next_st.rx_valid = '0;
    if (BIT_STROBE_I) begin
      next_st.next_pos = (frame_pos == tsa_pkg::LAST_FRAME_POS) ? '0
                         : frame_pos + tsa_pkg::FRAME_POS_W'(1);
      // lowest numbered controller wins if software overlaps two on one slot
      for (int k = tsa_pkg::NUM_CTRL - 1; k >= 0; k--) begin
        if (active[k]) begin
          tx_bit = CTRL_TX_DATA_I[k];
          winner = '0;
          winner[k] = 1'b1;
        end
      end
      next_st.tx_data = tx_bit;
      // only the controller whose bit went out is told it was taken
      next_st.tx_taken = winner;
      next_st.rx_valid = active;
      for (int k = 0; k < tsa_pkg::NUM_CTRL; k++) begin
        if (active[k]) begin
          next_st.rx_data[k] = LINE_RX_DATA_I;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      st <= '0;
      for (int k = 0; k < tsa_pkg::NUM_CTRL; k++) begin
        st.sel[k] <= tsa_pkg::SEL_RESET;
      end
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA_O = st.prdata;
  assign PREADY_O = st.pready;
  assign PSLVERR_O = st.pslverr;
  assign TX_DATA_O = st.tx_data;
  assign CTRL_TX_TAKEN_O = st.tx_taken;
  assign CTRL_RX_DATA_O = st.rx_data;
  assign CTRL_RX_VALID_O = st.rx_valid;
endmodule : hdlc_timeslot_attach

// ### logic/tsa_pkg.sv
// shared constants for the timeslot attach block
package tsa_pkg;
  localparam int NUM_CTRL = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 8;
  // register indices; byte address is four times the index
  localparam logic [7:0] REG_IDX_CTRL0 = 8'h19;
  localparam logic [7:0] REG_IDX_CTRL1 = 8'h1A;
  localparam logic [7:0] REG_IDX_CTRL2 = 8'h1B;
  localparam logic [ADDR_W-1:0] ADDR_CTRL0 = {REG_IDX_CTRL0[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = {REG_IDX_CTRL1[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CTRL2 = {REG_IDX_CTRL2[5:0], 2'h0};
  // select register fields
  localparam int EN_BIT = 7;
  localparam int SPARE_SEL_BIT = 6;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  localparam logic [SEL_W-1:0] SEL_RESET = 8'h00;
  localparam logic [SEL_W-1:0] MASK_CTRL0 = 8'hDF;
  localparam logic [SEL_W-1:0] MASK_CTRL12 = 8'h9F;
  // frame geometry
  localparam int BIT_IN_SLOT_W = 3;
  localparam int FRAME_POS_W = CHAN_W + BIT_IN_SLOT_W;
  localparam logic [FRAME_POS_W-1:0] LAST_FRAME_POS = 8'hFF;
  localparam logic [BIT_IN_SLOT_W-1:0] SPARE_FIRST_BIT = 3'h3;
  localparam logic [CHAN_W-1:0] CHAN_ZERO = 5'h00;
endpackage : tsa_pkg

// ### logic/slot_if.sv
// carrier between the top and one per-controller slot matcher
`timescale 1ns/1ps
interface slot_if;
  logic enable;
  logic payload_sel;
  logic [tsa_pkg::CHAN_W-1:0] channel_index;
  logic [tsa_pkg::FRAME_POS_W-1:0] frame_pos;
  logic align_frame;
  logic active;
  modport matcher (
    input enable,
    input payload_sel,
    input channel_index,
    input frame_pos,
    input align_frame,
    output active
  );
  modport owner (
    output enable,
    output payload_sel,
    output channel_index,
    output frame_pos,
    output align_frame,
    input active
  );
endinterface : slot_if

// ### logic/slot_matcher.sv
// decides whether the current frame bit belongs to one controller
`timescale 1ns/1ps
module slot_matcher #(
  parameter bit ALLOW_SPARE = 1'b0,
  parameter bit ALLOW_SLOT_ZERO = 1'b1
) (
  slot_if.matcher port_if
);
  logic [tsa_pkg::CHAN_W-1:0] slot;
  logic [tsa_pkg::BIT_IN_SLOT_W-1:0] bit_in_slot;
  logic spare_hit;
  logic slot_hit;

  always_comb begin
    slot = port_if.frame_pos[tsa_pkg::FRAME_POS_W-1:tsa_pkg::BIT_IN_SLOT_W];
    bit_in_slot = port_if.frame_pos[tsa_pkg::BIT_IN_SLOT_W-1:0];
    // spare bits sit in bits 4..8 of slot zero in frames without the alignment word
    spare_hit = (slot == tsa_pkg::CHAN_ZERO) && (bit_in_slot >= tsa_pkg::SPARE_FIRST_BIT)
                && !port_if.align_frame;
    // slot zero is never matched where it may not be assigned
    slot_hit = (slot == port_if.channel_index)
               && (ALLOW_SLOT_ZERO || (port_if.channel_index != tsa_pkg::CHAN_ZERO));
    if (!port_if.enable) begin
      port_if.active = 1'b0;
    end else if (ALLOW_SPARE && !port_if.payload_sel) begin
      port_if.active = spare_hit;
    end else begin
      port_if.active = slot_hit;
    end
  end
endmodule : slot_matcher

// ### tb/tsa_framer_model.sv
// framer-side model: bit strobes, frame start, alignment flag, serial and line bits
`timescale 1ns/1ps
module tsa_framer_model (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic strobe_o,
  output logic fstart_o,
  output logic align_o,
  output logic ser_o,
  output logic line_o,
  output logic [7:0] pos_o
);
  logic [1:0] gap;
  initial {strobe_o, fstart_o, align_o, ser_o, line_o, gap, pos_o} = '1;
  always @(posedge clk_i) begin
    if (rst_i) begin
      {strobe_o, fstart_o, align_o, ser_o, line_o, gap, pos_o} <= {7'h0, 8'hFF};
    end else if (gap == 2'h0) begin
      // varying bit spacing so the block cannot lean on a fixed strobe rate
      gap <= 2'($urandom_range(3, 1));
      strobe_o <= 1'b1;
      pos_o <= pos_o + 8'h01;
      fstart_o <= pos_o == 8'hFF;
      align_o <= align_o ^ (pos_o == 8'hFF);
      {ser_o, line_o} <= 2'($urandom);
    end else begin
      gap <= gap - 2'h1;
      {strobe_o, fstart_o} <= 2'h0;
      // bits are valid only with the strobe; afterwards the lines keep changing
      {ser_o, line_o} <= ~{ser_o, line_o};
    end
  end
endmodule : tsa_framer_model

// ### tb/tsa_properties.sv
// port-level assertions for the timeslot attach block
`timescale 1ns/1ps
module tsa_properties (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic BIT_STROBE_I,
  input wire logic FRAME_START_I,
  input wire logic SER_TX_DATA_I,
  input wire logic LINE_RX_DATA_I,
  input wire logic [2:0] CTRL_TX_DATA_I,
  input wire logic TX_DATA_O,
  input wire logic [2:0] CTRL_TX_TAKEN_O,
  input wire logic [2:0] CTRL_RX_DATA_O,
  input wire logic [2:0] CTRL_RX_VALID_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  taken_strobe_a: assert property (CTRL_TX_TAKEN_O != 3'h0 |-> $past(BIT_STROBE_I))
    else $error("taken without strobe");
  valid_strobe_a: assert property (CTRL_RX_VALID_O != 3'h0 |-> $past(BIT_STROBE_I))
    else $error("valid without strobe");
  ctrl0_sub_a: assert property (BIT_STROBE_I ##1 CTRL_TX_TAKEN_O[0] |->
    TX_DATA_O == $past(CTRL_TX_DATA_I[0])) else $error("tx not from controller zero");
  tx_pass_a: assert property (BIT_STROBE_I ##1 CTRL_TX_TAKEN_O == 3'h0 |->
    TX_DATA_O == $past(SER_TX_DATA_I)) else $error("tx not passed through");
  rx_tap_a: assert property (BIT_STROBE_I |=>
    ((CTRL_RX_DATA_O ^ {3{$past(LINE_RX_DATA_I)}}) & CTRL_RX_VALID_O) == 3'h0)
    else $error("rx bit not line bit");
  slot_zero_a: assert property (BIT_STROBE_I && FRAME_START_I |=>
    CTRL_RX_VALID_O[2:1] == 2'h0) else $error("slot zero given to controller one or two");
  one_driver_a: assert property ($onehot0(CTRL_TX_TAKEN_O) &&
    (CTRL_TX_TAKEN_O & ~CTRL_RX_VALID_O) == 3'h0) else $error("tx owner mismatch");
  ctrl0_pair_a: assert property (CTRL_TX_TAKEN_O[0] == CTRL_RX_VALID_O[0])
    else $error("controller zero tx and rx slots differ");
  hold_bits_a: assert property (!BIT_STROBE_I |=> $stable(TX_DATA_O)
    && $stable(CTRL_RX_DATA_O)) else $error("outputs moved without strobe");
  cover property (CTRL_TX_TAKEN_O[0]);
  cover property (CTRL_RX_VALID_O[1] && CTRL_RX_VALID_O[2]);
  cover property (BIT_STROBE_I ##1 CTRL_TX_TAKEN_O == 3'h0);
endmodule : tsa_properties
bind hdlc_timeslot_attach tsa_properties u_props (.CLK_SYS_I, .SYS_RST_I, .BIT_STROBE_I,
  .FRAME_START_I, .SER_TX_DATA_I, .LINE_RX_DATA_I, .CTRL_TX_DATA_I, .TX_DATA_O,
  .CTRL_TX_TAKEN_O, .CTRL_RX_DATA_O, .CTRL_RX_VALID_O);

// ### tb/hdlc_timeslot_attach_tb.sv
// bench: select registers over apb, corner and random slot plans, per-bit scoreboard
`timescale 1ns/1ps
module hdlc_timeslot_attach_tb;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, stb, fs, al, ser, lin, chk = 0, vld = 0;
  logic [7:0] paddr = 0, pos, sel [3];
  logic [31:0] pwd = 0, prd, rd;
  logic [2:0] ctx = 0, tk, rv, rdat, etk, erv;
  logic tx, pre, err, etx, eln, erro;
  logic [23:0] plan [4] = '{24'h809F9F, 24'hDF9F00, 24'hC08181, 24'h000000};
  int bad_count = 0, n_compared = 0, cyc = 0;
  hdlc_timeslot_attach dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pre),
    .PSLVERR_O(err), .BIT_STROBE_I(stb), .FRAME_START_I(fs), .ALIGN_FRAME_I(al),
    .SER_TX_DATA_I(ser), .LINE_RX_DATA_I(lin), .CTRL_TX_DATA_I(ctx), .TX_DATA_O(tx),
    .CTRL_TX_TAKEN_O(tk), .CTRL_RX_DATA_O(rdat), .CTRL_RX_VALID_O(rv));
  tsa_framer_model fm (.clk_i(clk), .rst_i(rst), .strobe_o(stb), .fstart_o(fs),
    .align_o(al), .ser_o(ser), .line_o(lin), .pos_o(pos));
  initial forever #2.5 clk = ~clk;
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pre !== 1'b1);
    rd = prd;
    erro = err;
    {psel, pen} <= 2'b00;
  endtask : apb
  function automatic logic hit(int k, logic [7:0] s, logic [7:0] p, logic a);
    if (!s[7]) return 1'b0;
    if (k == 0 && !s[6]) return p[7:3] == 5'h00 && p[2:0] >= 3'h3 && !a;
    return p[7:3] == s[4:0] && (k == 0 || s[4:0] != 5'h00);
  endfunction : hit
  always @(posedge clk) begin
    cyc++;
    if (cyc > 40000) begin
      bad_count++;
      report_and_stop();
    end
  end
  always @(posedge clk) begin
    if (chk && vld) begin
      check("taken", tk, etk);
      check("valid", rv, erv);
      check("tx", tx, etx);
      check("rxdata", rdat & erv, {3{eln}} & erv);
    end
    vld = stb;
    {etx, eln, erv, etk} = {ser, lin, 6'h00};
    // lowest index wins the transmit slot, so walk down to zero
    for (int k = 2; k >= 0; k--) if (hit(k, sel[k], pos, al)) begin
      erv[k] = 1'b1;
      etk = 3'h1 << k;
      etx = ctx[k];
    end
    ctx <= 3'($urandom);
  end
  initial begin
    void'($urandom(71));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, tsa_pkg::ADDR_CTRL0 + 8'(4 * k), 32'h0);
      check("reset value", rd, 32'h0);
      check("unmapped error", {31'h0, erro}, {31'h0, k == 3});
    end
    for (int t = 0; t < 8; t++) begin
      chk <= 1'b0;
      {sel[0], sel[1], sel[2]} = plan[t % 4];
      // random plans keep slot zero away from controllers one and two, spare bits zero
      if (t > 3) sel = '{8'($urandom) & tsa_pkg::MASK_CTRL0,
        {1'($urandom), 2'h0, 5'($urandom_range(31, 1))}, 8'h9F};
      for (int k = 0; k < 3; k++) begin
        apb(1'b1, tsa_pkg::ADDR_CTRL0 + 8'(4 * k), {24'h0, sel[k]});
        apb(1'b0, tsa_pkg::ADDR_CTRL0 + 8'(4 * k), 32'h0);
        check("readback", rd, {24'h0, sel[k]});
      end
      do @(posedge clk); while (!(stb && fs));
      chk <= 1'b1;
      do @(posedge clk); while (!(stb && fs));
      $display("test %0d done", t);
    end
    report_and_stop();
  end
endmodule : hdlc_timeslot_attach_tb
